// ---- common/mhcp_pkg.sv ----
package mhcp_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_HZ       = 20_000_000;
  localparam int CLK_PER_US   = CLK_HZ / 1_000_000;
  localparam int SUSP_US      = 104;
  localparam int SUSP_CYCLES  = SUSP_US * CLK_PER_US;
  localparam int UNIT_CYCLES  = 12;
  localparam int EXEC_UNITS   = 4;
  localparam int EXEC_CYCLES  = EXEC_UNITS * UNIT_CYCLES;
  localparam logic [11:0] SUSP_LOAD = 12'(SUSP_CYCLES);
  localparam logic [7:0]  EXEC_LOAD = 8'(EXEC_CYCLES);

  // ************************************************************
  // Address latch layout
  // ************************************************************
  localparam int          ADDR_SEL_BIT  = 8;
  localparam int          ADDR_EXEC_BIT = 3;
  localparam logic [3:0]  SELECT_NIBBLE = 4'h2;

  // ************************************************************
  // Direct register indices
  // ************************************************************
  localparam logic [2:0] IDX_CMD     = 3'h0;
  localparam logic [2:0] IDX_DATA1   = 3'h1;
  localparam logic [2:0] IDX_AUX_HI  = 3'h4;
  localparam logic [2:0] IDX_AUX_LO  = 3'h5;
  localparam logic [2:0] IDX_MAIN_HI = 3'h6;
  localparam logic [2:0] IDX_MAIN_LO = 3'h7;

  // ************************************************************
  // Status bits and command parameter bits
  // ************************************************************
  localparam int ST_BUSY  = 7;
  localparam int ST_ALARM = 6;
  localparam int ST_MLAST = 5;
  localparam int ST_ALAST = 4;
  localparam int ST_DMSB  = 3;
  localparam int ST_VSYNC = 2;
  localparam int CP_DIR   = 3;
  localparam int CP_PSEL  = 2;
  localparam int CP_INCR  = 0;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [3:0] TY_RSRC = 4'h8;
  localparam logic [3:0] TY_K24  = 4'h0;
  localparam logic [3:0] TY_KRE  = 4'h1;
  localparam logic [3:0] TY_OCT  = 4'h3;
  localparam logic [3:0] TY_K8   = 4'h4;
  localparam logic [3:0] TY_K12  = 4'h5;
  localparam logic [3:0] TY_MISC = 4'h9;
  localparam logic [3:0] TY_INY  = 4'hb;
  localparam logic [7:0] CMD_MSK = 8'h99;
  localparam logic [7:0] CMD_UNM = 8'h95;
  localparam logic [1:0] SD_M2A  = 2'h1;
  localparam logic [1:0] SD_A2M  = 2'h2;
  localparam logic [1:0] STOP_END  = 2'h1;
  localparam logic [1:0] STOP_NONE = 2'h2;

  // ************************************************************
  // Values after reset and sizes
  // ************************************************************
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h91;
  localparam logic [5:0] LAST_COL  = 6'h27;
  localparam int         IND_COUNT = 5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } mhcp_state_t;

endpackage

// ---- core/mhcp_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Address strobe fall latches bus and select
// - Index, execute flag, select nibble fields
// - Selected only when nibble 2, select low
// - Unselected: pins float, registers untouched
// - Selected data phase accesses indexed register
// - Index 0 command/status, 1-7 arguments
// - Command byte: type plus four parameters
// - Direction and increment parameter meanings
// - Pointer select and source/destination field
// - Move stop: buffer end or never
// - Busy set at launch, cleared at end
// - Last-column flags when column was 39
// - Alarm when last column and incremented
// - Status: data msb, vsync, zero bits
// - Flags cleared at start, set after
// - Launch on data strobe end if requested
// - Busy, no request: status read only
// - Busy, request: new command aborts old
// - Pause 104 us except sync mask commands
// - Indirect command moves byte to or from one of five registers
// - Code commands use main pointer, wrap column, row kept
// - Vsync mask forces status bit 2 low
module mhcp_core
  import mhcp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [7:0] bus_in,
  output var  logic [7:0] bus_out,
  output var  logic       bus_oe,
  input  wire logic       addr_strobe,
  input  wire logic       data_strobe_n,
  input  wire logic       host_read,
  input  wire logic       chip_sel_n,
  input  wire logic       vsync_n,
  input  wire logic       row_edge
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [13:0] s1_reg;
  logic [13:0] s2_reg;
  logic [13:0] s_next;
  logic        astb_d_reg;
  logic        dstb_d_reg;
  logic        re_d_reg;

  always_comb begin
    s_next = {row_edge, vsync_n, chip_sel_n, host_read,
              data_strobe_n, addr_strobe, bus_in};
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_reg   <= 14'h3f00;
      s2_reg   <= 14'h3f00;
      astb_d_reg <= 1'b1;
      dstb_d_reg <= 1'b1;
      re_d_reg <= 1'b1;
    end else begin
      s1_reg   <= s_next;
      s2_reg   <= s1_reg;
      astb_d_reg <= s2_reg[8];
      dstb_d_reg <= s2_reg[9];
      re_d_reg <= s2_reg[13];
    end
  end

  logic [7:0] bus_s;
  logic       astb_s;
  logic       dstb_s;
  logic       rd_s;
  logic       cs_s;
  logic       vs_s;
  logic       astb_fall;
  logic       dstb_rise;
  logic       edge_rise;

  always_comb begin
    bus_s     = s2_reg[7:0];
    astb_s    = s2_reg[8];
    dstb_s    = s2_reg[9];
    rd_s      = s2_reg[10];
    cs_s      = s2_reg[11];
    vs_s      = s2_reg[12];
    astb_fall = astb_d_reg & ~astb_s;
    dstb_rise = ~dstb_d_reg & dstb_s;
    edge_rise = ~re_d_reg & s2_reg[13];
  end

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic main_code_cmd(input logic [7:0] c);
    main_code_cmd = ((c[7:4] == TY_K24) && !c[2]) ||
                    (c[7:4] == TY_KRE) || (c[7:4] == TY_K8) ||
                    (c[7:4] == TY_K12);
  endfunction

  function automatic logic sync_cmd(input logic [7:0] c);
    sync_cmd = (c == CMD_MSK) || (c == CMD_UNM);
  endfunction

  function automatic logic [7:0] bump_col(input logic [7:0] p);
    bump_col = (p[5:0] == LAST_COL) ? {p[7:6], 6'h00}
                                    : {p[7:6], p[5:0] + 6'h01};
  endfunction

  // ************************************************************
  // Port and command state
  // ************************************************************
  logic [8:0]  addr_reg,  addr_next;
  logic [7:0]  cmd_reg,   cmd_next;
  logic [7:0]  arg_reg  [1:7];
  logic [7:0]  arg_next [1:7];
  logic [7:0]  ind_reg  [0:IND_COUNT-1];
  logic [7:0]  ind_next [0:IND_COUNT-1];
  logic        alarm_reg, alarm_next;
  logic        mlast_reg, mlast_next;
  logic        alast_reg, alast_next;
  logic        msb_reg,   msb_next;
  logic        mask_reg,  mask_next;
  logic [7:0]  cnt_reg,   cnt_next;
  logic [11:0] susp_reg,  susp_next;
  logic [7:0]  dout_reg,  dout_next;
  logic        oe_reg,    oe_next;
  mhcp_state_t st_reg,    st_next;

  logic       selected;
  logic       exec_request;
  logic [2:0] idx;
  logic       busy;
  logic [7:0] status;
  logic       wr_ok;
  logic       launch;
  logic       paused;
  logic [2:0] r_sel;

  always_comb begin
    idx      = addr_reg[2:0];
    exec_request = addr_reg[ADDR_EXEC_BIT];
    selected = (addr_reg[7:4] == SELECT_NIBBLE) &&
               !addr_reg[ADDR_SEL_BIT];
    busy     = (st_reg != ST_IDLE);
    status   = {busy, alarm_reg, mlast_reg, alast_reg, msb_reg,
                vs_s & ~mask_reg, 2'b00};
    // Busy: only a command write with the request flag lands.
    wr_ok    = !busy || (exec_request && idx == IDX_CMD);
    launch   = selected && exec_request && dstb_rise && !astb_s;
    paused   = (susp_reg != 12'h000) && !sync_cmd(cmd_reg);
    r_sel    = cmd_reg[2:0];
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [7:0] ptr;
    logic       lx;
    ptr        = REG_RESET;
    lx         = 1'b0;
    addr_next  = addr_reg;
    cmd_next   = cmd_reg;
    arg_next   = arg_reg;
    ind_next   = ind_reg;
    alarm_next = alarm_reg;
    mlast_next = mlast_reg;
    alast_next = alast_reg;
    msb_next   = msb_reg;
    mask_next  = mask_reg;
    cnt_next   = cnt_reg;
    susp_next  = susp_reg;
    st_next    = st_reg;
    dout_next  = REG_RESET;
    oe_next    = 1'b0;

    if (astb_fall) begin
      addr_next = {cs_s, bus_s};
    end

    // Reads drive the pins only inside a selected data phase.
    if (selected && !astb_s && !dstb_s && rd_s) begin
      oe_next = 1'b1;
      if (idx == IDX_CMD) begin
        dout_next = status;
      end else if (!busy) begin
        dout_next = arg_reg[idx];
      end
    end

    if (edge_rise) begin
      susp_next = SUSP_LOAD;
    end else if (susp_reg != 12'h000) begin
      susp_next = susp_reg - 12'h001;
    end

    if (st_reg == ST_RUN && !paused) begin
      st_next = ST_HOLD;
    end else if (st_reg == ST_HOLD) begin
      if (paused) begin
        st_next = ST_RUN;
      end else if (cnt_reg != 8'h00) begin
        cnt_next = cnt_reg - 8'h01;
      end else begin
        st_next = ST_IDLE;
        unique case (cmd_reg[7:4])
          TY_RSRC: begin
            if (r_sel < 3'(IND_COUNT)) begin
              if (cmd_reg[CP_DIR]) begin
                arg_next[IDX_DATA1] = ind_reg[r_sel];
              end else begin
                ind_next[r_sel] = arg_reg[IDX_DATA1];
              end
            end
          end
          TY_MISC: begin
            if (cmd_reg == CMD_MSK) begin
              mask_next = 1'b1;
            end else if (cmd_reg == CMD_UNM) begin
              mask_next = 1'b0;
            end
          end
          TY_INY: begin
            arg_next[IDX_MAIN_HI] = arg_reg[IDX_MAIN_HI] + 8'h01;
          end
          TY_OCT: begin
            ptr = cmd_reg[CP_PSEL] ? arg_reg[IDX_AUX_LO]
                                   : arg_reg[IDX_MAIN_LO];
            lx  = (ptr[5:0] == LAST_COL);
            if (cmd_reg[CP_PSEL]) begin
              alast_next = lx;
            end else begin
              mlast_next = lx;
            end
            if (cmd_reg[CP_INCR]) begin
              alarm_next = lx;
              if (cmd_reg[CP_PSEL]) begin
                arg_next[IDX_AUX_LO] = bump_col(ptr);
              end else begin
                arg_next[IDX_MAIN_LO] = bump_col(ptr);
              end
            end
            msb_next = arg_reg[IDX_DATA1][7];
          end
          4'hd, 4'he, 4'hf: begin
            // A move with no stop only ends by being aborted.
            if (cmd_reg[1:0] == STOP_NONE) begin
              st_next  = ST_HOLD;
              cnt_next = EXEC_LOAD;
            end else if (cmd_reg[1:0] == STOP_END &&
                         (cmd_reg[3:2] == SD_M2A ||
                          cmd_reg[3:2] == SD_A2M)) begin
              arg_next[IDX_MAIN_LO] = bump_col(arg_reg[IDX_MAIN_LO]);
              arg_next[IDX_AUX_LO]  = bump_col(arg_reg[IDX_AUX_LO]);
            end
          end
          default: begin
            if (main_code_cmd(cmd_reg)) begin
              lx       = (arg_reg[IDX_MAIN_LO][5:0] == LAST_COL);
              mlast_next = lx;
              if (cmd_reg[CP_INCR]) begin
                alarm_next = lx;
                arg_next[IDX_MAIN_LO] =
                  bump_col(arg_reg[IDX_MAIN_LO]);
              end
              msb_next = arg_reg[IDX_DATA1][7];
            end
          end
        endcase
      end
    end

    // Host writes land on the trailing edge of the data strobe.
    if (selected && dstb_rise && !astb_s && !rd_s && wr_ok) begin
      if (idx == IDX_CMD) begin
        cmd_next = bus_s;
      end else begin
        arg_next[idx] = bus_s;
      end
    end

    // A launch restarts the engine unless busy with a write to an argument index; a running command is abandoned.
    if (launch && (!busy || rd_s || idx == IDX_CMD)) begin
      st_next    = ST_RUN;
      cnt_next   = EXEC_LOAD;
      alarm_next = 1'b0;
      mlast_next = 1'b0;
      alast_next = 1'b0;
      msb_next   = 1'b0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr_reg  <= 9'h100;
      cmd_reg   <= CMD_RESET;
      alarm_reg <= 1'b0;
      mlast_reg <= 1'b0;
      alast_reg <= 1'b0;
      msb_reg   <= 1'b0;
      mask_reg  <= 1'b0;
      cnt_reg   <= 8'h00;
      susp_reg  <= 12'h000;
      dout_reg  <= REG_RESET;
      oe_reg    <= 1'b0;
      st_reg    <= ST_IDLE;
    end else begin
      addr_reg  <= addr_next;
      cmd_reg   <= cmd_next;
      alarm_reg <= alarm_next;
      mlast_reg <= mlast_next;
      alast_reg <= alast_next;
      msb_reg   <= msb_next;
      mask_reg  <= mask_next;
      cnt_reg   <= cnt_next;
      susp_reg  <= susp_next;
      dout_reg  <= dout_next;
      oe_reg    <= oe_next;
      st_reg    <= st_next;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < 8; gi++) begin : g_arg
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          arg_reg[gi] <= REG_RESET;
        end else begin
          arg_reg[gi] <= arg_next[gi];
        end
      end
    end
    for (gi = 0; gi < IND_COUNT; gi++) begin : g_ind
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          ind_reg[gi] <= REG_RESET;
        end else begin
          ind_reg[gi] <= ind_next[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    bus_out = dout_reg;
    bus_oe  = oe_reg;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_start;
    launch && (!busy || rd_s || idx == IDX_CMD);
  endsequence
  sequence s_running;
    st_reg != ST_IDLE;
  endsequence

  chk_addr_latch: assert property (astb_fall |=> addr_reg == {$past(cs_s), $past(bus_s)})
    else $error("address latch missed strobe fall");
  chk_float_unsel: assert property (!selected |=> !oe_reg)
    else $error("bus driven while unselected");
  chk_busy_launch: assert property (s_start |=> s_running[*2])
    else $error("busy not raised on launch");
  chk_flags_clear: assert property (s_start |=> !alarm_reg && !mlast_reg && !alast_reg)
    else $error("status flags not cleared at start");
  chk_alarm_cause: assert property ($rose(alarm_reg) |-> $past(mlast_next) || $past(alast_next))
    else $error("alarm without last column");
  chk_mask_status: assert property (mask_reg && oe_next && idx == IDX_CMD |=> !bus_out[ST_VSYNC])
    else $error("status bit 2 set under mask");
  chk_status_read: assert property (oe_next && idx == IDX_CMD |=> bus_out == $past(status))
    else $error("status read mismatch");
  chk_pause_hold: assert property (st_reg == ST_RUN && paused |=> st_reg == ST_RUN)
    else $error("command ran during pause");
  chk_busy_wr: assert property (busy && !exec_request && dstb_rise |=> cmd_reg == $past(cmd_reg))
    else $error("command changed while busy");
  chk_col_wrap: assert property (st_reg == ST_HOLD && cnt_reg == 8'h00 && !paused
      && main_code_cmd(cmd_reg) && cmd_reg[CP_INCR]
      && arg_reg[IDX_MAIN_LO][5:0] == LAST_COL && !launch
      |=> arg_reg[IDX_MAIN_LO][5:0] == 6'h00 && mlast_reg)
    else $error("main pointer did not wrap");

endmodule
`default_nettype wire

// ---- verification/mhcp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Host processor on the multiplexed bus
// ************************************************************
module mhcp_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe,
  output var  logic [7:0] bus_in,
  output var  logic       addr_strobe,
  output var  logic       data_strobe_n,
  output var  logic       host_read,
  output var  logic       chip_sel_n
);
  initial begin
    bus_in        = 8'h00;
    addr_strobe   = 1'b1;
    data_strobe_n = 1'b1;
    host_read     = 1'b1;
    chip_sel_n    = 1'b1;
  end

  // Every phase is held well past the device's two-flop input sync, so no edge is missed.
  task automatic cycle(input logic [7:0] addr, input logic cs_n, input logic rd,
                       input logic [7:0] wdata, output logic [7:0] rdata, output logic oe);
    @(negedge sys_clk);
    bus_in     = addr;
    chip_sel_n = cs_n;
    host_read  = rd;
    repeat (4) @(negedge sys_clk);
    addr_strobe = 1'b0;
    repeat (5) @(negedge sys_clk);
    // A released bus shows the inverse of the address, so a stale value never passes.
    bus_in = rd ? ~addr : wdata;
    repeat (4) @(negedge sys_clk);
    data_strobe_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    rdata         = bus_out;
    oe            = bus_oe;
    data_strobe_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    addr_strobe = 1'b1;
    chip_sel_n  = 1'b1;
    bus_in      = ~bus_in;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_muxed_host_command_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_muxed_host_command_port
  import mhcp_pkg::*;
;
  logic       sys_clk;
  logic       srst;
  logic       vsync_n;
  logic       row_edge;
  logic [7:0] bus_in;
  logic [7:0] bus_out;
  logic       bus_oe;
  logic       addr_strobe;
  logic       data_strobe_n;
  logic       host_read;
  logic       chip_sel_n;
  logic [7:0] s;
  logic [7:0] q;
  logic       oe;
  int         err_total;
  int         samples_checked;

  mhcp_core u_dut (.sys_clk(sys_clk), .srst(srst), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .addr_strobe(addr_strobe), .data_strobe_n(data_strobe_n), .host_read(host_read),
    .chip_sel_n(chip_sel_n), .vsync_n(vsync_n), .row_edge(row_edge));
  mhcp_host_model u_host (.sys_clk(sys_clk), .bus_out(bus_out), .bus_oe(bus_oe), .bus_in(bus_in),
    .addr_strobe(addr_strobe), .data_strobe_n(data_strobe_n), .host_read(host_read),
    .chip_sel_n(chip_sel_n));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] i, input logic x, input logic [7:0] d);
    logic [7:0] r;
    logic       o;
    u_host.cycle({SELECT_NIBBLE, x, i}, 1'b0, 1'b0, d, r, o);
  endtask

  task automatic rd(input logic [2:0] i, output logic [7:0] r);
    logic o;
    u_host.cycle({SELECT_NIBBLE, 1'b0, i}, 1'b0, 1'b1, 8'h00, r, o);
  endtask

  task automatic run(input logic [7:0] c);
    wr(IDX_CMD, 1'b1, c);
  endtask

  task automatic idle(input int lim, output logic [7:0] st);
    int n;
    n  = 0;
    st = 8'h80;
    while (st[ST_BUSY] !== 1'b0 && n < lim) begin
      rd(IDX_CMD, st);
      n++;
    end
    `CHK("busy_end", 1'b0, st[ST_BUSY])
    if (st[ST_BUSY] !== 1'b0) results();
  endtask

  task automatic pulse_row();
    row_edge = 1'b1;
    repeat (4) @(negedge sys_clk);
    row_edge = 1'b0;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    srst            = 1'b1;
    vsync_n         = 1'b1;
    row_edge        = 1'b0;
    err_total       = 0;
    samples_checked = 0;
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    repeat (3) @(negedge sys_clk);
    rd(IDX_CMD, s);
    `CHK("st_low", 2'h0, s[1:0])
    rd(IDX_DATA1, q);
    `CHK("r1_reset", REG_RESET, q)
    run(8'h91);
    idle(10, s);
    $display("test reset done");

    for (int i = 1; i < 8; i++) begin
      wr(3'(i), 1'b0, {1'b0, 3'(i), 1'b1, 3'(i)});
    end
    for (int i = 1; i < 8; i++) begin
      rd(3'(i), q);
      `CHK("arg_reg", {1'b0, 3'(i), 1'b1, 3'(i)}, q)
    end
    u_host.cycle({SELECT_NIBBLE, 1'b0, IDX_DATA1}, 1'b0, 1'b1, 8'h00, q, oe);
    `CHK("oe_sel", 1'b1, oe)
    u_host.cycle({SELECT_NIBBLE, 1'b0, IDX_DATA1}, 1'b1, 1'b0, 8'haa, q, oe);
    u_host.cycle({4'h3, 1'b0, IDX_DATA1}, 1'b0, 1'b0, 8'hbb, q, oe);
    u_host.cycle({4'h3, 1'b0, IDX_DATA1}, 1'b0, 1'b1, 8'h00, q, oe);
    `CHK("oe_unsel", 1'b0, oe)
    u_host.cycle({SELECT_NIBBLE, 1'b1, IDX_CMD}, 1'b1, 1'b0, 8'h01, q, oe);
    wr(IDX_CMD, 1'b0, 8'h01);
    rd(IDX_CMD, s);
    `CHK("no_launch", 1'b0, s[ST_BUSY])
    rd(IDX_DATA1, q);
    `CHK("r1_unsel", 8'h19, q)
    $display("test select done");

    wr(IDX_MAIN_HI, 1'b0, 8'h05);
    wr(IDX_MAIN_LO, 1'b0, {2'b00, LAST_COL});
    wr(IDX_DATA1, 1'b0, 8'h80);
    run({TY_K24, 4'h1});
    rd(IDX_CMD, s);
    `CHK("busy_set", 1'b1, s[ST_BUSY])
    idle(10, s);
    `CHK("mlast_set", 1'b1, s[ST_MLAST])
    `CHK("st_k24", 8'h6c, s)
    rd(IDX_MAIN_LO, q);
    `CHK("mp_wrap", 8'h00, q)
    rd(IDX_MAIN_HI, q);
    `CHK("mp_row", 8'h05, q)
    run({TY_INY, 4'h0});
    idle(10, s);
    rd(IDX_MAIN_HI, q);
    `CHK("mp_row_inc", 8'h06, q)
    wr(IDX_DATA1, 1'b0, 8'h00);
    run({TY_K24, 4'h0});
    rd(IDX_CMD, s);
    `CHK("st_start", 5'h10, s[7:3])
    idle(10, s);
    `CHK("st_noinc", 8'h04, s)
    $display("test code done");

    run(8'hd6);
    wr(3'h2, 1'b0, 8'h55);
    wr(3'h3, 1'b1, 8'h66);
    rd(3'h2, q);
    `CHK("arg_busy", 8'h00, q)
    rd(IDX_CMD, s);
    `CHK("move_run", 1'b1, s[ST_BUSY])
    run(8'h91);
    idle(10, s);
    rd(3'h2, q);
    `CHK("r2_kept", 8'h2a, q)
    rd(3'h3, q);
    `CHK("r3_kept", 8'h3b, q)
    $display("test abort done");

    for (int r = 0; r < IND_COUNT; r++) begin
      wr(IDX_DATA1, 1'b0, 8'(8'h30 + r));
      run({TY_RSRC, 1'b0, 3'(r)});
      idle(10, s);
    end
    for (int r = 0; r < IND_COUNT; r++) begin
      run({TY_RSRC, 1'b1, 3'(r)});
      idle(10, s);
      rd(IDX_DATA1, q);
      `CHK("ind_reg", 8'(8'h30 + r), q)
    end
    $display("test indirect done");

    run(CMD_MSK);
    idle(10, s);
    `CHK("vs_mask", 1'b0, s[ST_VSYNC])
    run(CMD_UNM);
    idle(10, s);
    `CHK("vs_high", 1'b1, s[ST_VSYNC])
    vsync_n = 1'b0;
    rd(IDX_CMD, s);
    `CHK("vs_low", 1'b0, s[ST_VSYNC])
    vsync_n = 1'b1;
    wr(IDX_AUX_LO, 1'b0, {2'b00, LAST_COL});
    run({TY_OCT, 4'h5});
    idle(10, s);
    `CHK("aux_last", 3'b101, s[6:4])
    run({4'hd, SD_M2A, STOP_END});
    idle(10, s);
    rd(IDX_MAIN_LO, q);
    `CHK("move_main", 8'h01, q)
    rd(IDX_AUX_LO, q);
    `CHK("move_aux", 8'h01, q)
    $display("test status done");

    run({TY_K24, 4'h0});
    pulse_row();
    repeat (3) rd(IDX_CMD, s);
    `CHK("paused", 1'b1, s[ST_BUSY])
    idle(200, s);
    pulse_row();
    run(CMD_MSK);
    idle(4, s);
    $display("test pause done");
    results();
  end
endmodule
`undef CHK
`default_nettype wire
